// [verilog/rpab_pkg.sv]
// Constants and types for the receive-port alias and back-channel register bank
package rpab_pkg;

  // ***************************************************************
  // Bus and register indices (byte address is four times the index)
  // ***************************************************************
  localparam int RPAB_ADR_W = 10;
  localparam logic [7:0] RPAB_IDX_ALIAS5 = 8'h6a;
  localparam logic [7:0] RPAB_IDX_ALIAS6 = 8'h6b;
  localparam logic [7:0] RPAB_IDX_ALIAS7 = 8'h6c;
  localparam logic [7:0] RPAB_IDX_PORT_CFG = 8'h6d;
  localparam logic [7:0] RPAB_IDX_BC_SRC = 8'h6e;
  localparam logic [7:0] RPAB_IDX_STATUS = 8'h7f;
  localparam int RPAB_NUM_SLOTS = 3;
  localparam logic [2:0] RPAB_FIRST_SLOT = 3'h5;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int RPAB_ALIAS_LSB = 1;
  localparam int RPAB_AUTO_ACK_BIT = 0;
  localparam logic [7:0] RPAB_ALIAS_RST = 8'h00;
  localparam int RPAB_CFG_DROP_BIT = 3;
  localparam int RPAB_CFG_RSVD2_BIT = 2;
  localparam logic RPAB_CFG_DROP_RST = 1'b1;
  localparam logic [1:0] RPAB_CFG_MODE_RST = 2'h0;
  localparam logic [3:0] RPAB_CFG_RSVD_HI = 4'h0;
  localparam int RPAB_BC_SEL1_LSB = 4;
  localparam logic [7:0] RPAB_BC_RST = 8'h88;

  // ***************************************************************
  // Encodings
  // ***************************************************************
  localparam logic [1:0] RPAB_MODE_RESERVED = 2'h0;
  localparam logic [1:0] RPAB_MODE_RAW12_LF = 2'h1;
  localparam logic [1:0] RPAB_MODE_RAW12_HF = 2'h2;
  localparam logic [1:0] RPAB_MODE_RAW10 = 2'h3;
  localparam logic [3:0] RPAB_BC_CONST0 = 4'h8;
  localparam logic [3:0] RPAB_BC_CONST1 = 4'h9;
  localparam logic [3:0] RPAB_BC_FSYNC = 4'ha;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int RPAB_CLK_PERIOD_NS = 4;
  localparam int RPAB_FRAME_LINE_SETUP_NS = 8;
  localparam int RPAB_SETUP_CYC = (RPAB_FRAME_LINE_SETUP_NS + RPAB_CLK_PERIOD_NS - 1)
                                  / RPAB_CLK_PERIOD_NS;

  typedef enum logic [1:0] {FL_IDLE, FL_WAIT, FL_DROP, FL_RUN} rpab_line_e;

endpackage

// [verilog/rpab_bc_mux.sv]
// Source selector for one back-channel bit
`timescale 1ns/1ns
`default_nettype none
module rpab_bc_mux
  import rpab_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] sel_i,
  input wire logic [7:0] pin_i,
  input wire logic trigger_i,
  output logic bit_o
);

  logic bit_d;
  logic bit_q;

  always_comb begin
    bit_d = 1'b0;
    if (!sel_i[3]) begin
      bit_d = pin_i[sel_i[2:0]];
    end else begin
      case (sel_i)
        RPAB_BC_CONST1: bit_d = 1'b1;
        RPAB_BC_FSYNC: bit_d = trigger_i;
        default: bit_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
    end
  end

  assign bit_o = bit_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_BC_CONST: assert property (sel_i == RPAB_BC_CONST0 |=> !bit_o)
    else $error("constant zero source not zero");
  AST_BC_FSYNC: assert property (sel_i == RPAB_BC_FSYNC |=> bit_o == $past(trigger_i))
    else $error("frame sync source not followed");

endmodule
`default_nettype wire

// [verilog/rpab_cfg.sv]
// Receive-port alias decode, input format and back-channel source register bank
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module rpab_cfg
  import rpab_pkg::*;
#(
  parameter int ADR_W = RPAB_ADR_W,
  parameter int SETUP_CYC = RPAB_SETUP_CYC,
  parameter logic RSVD_BIT2 = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic txn_valid_i,
  input wire logic [6:0] txn_addr_i,
  input wire logic txn_write_i,
  input wire logic [6:0] target_id_slot5_i,
  input wire logic [6:0] target_id_slot6_i,
  input wire logic [6:0] target_id_slot7_i,
  input wire logic fwd_lock_i,
  input wire logic remote_ack_i,
  output logic match_o,
  output logic [2:0] match_slot_o,
  output logic [6:0] remote_addr_o,
  output logic match_write_o,
  output logic auto_ack_o,
  output logic i2c_ack_o,
  input wire logic frame_valid_i,
  input wire logic line_valid_i,
  output logic frame_valid_o,
  output logic line_valid_o,
  output logic trunc_line_o,
  output logic [1:0] input_format_select_o,
  output logic raw_mode_o,
  input wire logic [7:0] gpio_pin_i,
  input wire logic camera_trigger_signal_i,
  output logic backchannel_bit0_o,
  output logic backchannel_bit1_o
);

  localparam logic [7:0] SETUP_CNT = 8'(SETUP_CYC);

  // ***************************************************************
  // Pin synchroniser
  // ***************************************************************
  logic [7:0] gpio_s1_q;
  logic [7:0] gpio_s2_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_s1_q <= 8'h00;
      gpio_s2_q <= 8'h00;
    end else begin
      gpio_s1_q <= gpio_pin_i;
      gpio_s2_q <= gpio_s1_q;
    end
  end

  // ***************************************************************
  // Wishbone slave
  // ***************************************************************
  logic [7:0] idx;
  logic req;
  logic wr_en;
  logic ack_d, ack_q;
  logic [31:0] rdat_d, rdat_q;
  logic [7:0] rd_val;
  logic [7:0] alias_d [RPAB_NUM_SLOTS];
  logic [7:0] alias_q [RPAB_NUM_SLOTS];
  logic drop_d, drop_q;
  logic [1:0] mode_d, mode_q;
  logic [7:0] bc_d, bc_q;
  logic [7:0] status;
  rpab_line_e st_d, st_q;
  logic [2:0] slot_d, slot_q;

  assign idx = 8'(wb_adr_i[ADR_W-1:2]);
  assign req = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wr_en = req & wb_we_i & ack_q & wb_sel_i[0];
  assign status = {1'b0, slot_q, 2'b00, (st_q == FL_DROP), frame_valid_o};

  always_comb begin
    rd_val = 8'h00;
    case (idx)
      RPAB_IDX_ALIAS5: rd_val = alias_q[0];
      RPAB_IDX_ALIAS6: rd_val = alias_q[1];
      RPAB_IDX_ALIAS7: rd_val = alias_q[2];
      RPAB_IDX_PORT_CFG: rd_val = {RPAB_CFG_RSVD_HI, drop_q, RSVD_BIT2, mode_q};
      RPAB_IDX_BC_SRC: rd_val = bc_q;
      RPAB_IDX_STATUS: rd_val = status;
      default: rd_val = 8'h00;
    endcase
  end

  always_comb begin
    ack_d = req & ~ack_q;
    rdat_d = 32'h0;
    if (req && !ack_q && !wb_we_i) begin
      rdat_d = {24'h0, rd_val};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ***************************************************************
  // Register storage
  // ***************************************************************
  always_comb begin
    alias_d = alias_q;
    drop_d = drop_q;
    mode_d = mode_q;
    bc_d = bc_q;
    if (wr_en) begin
      for (int k = 0; k < RPAB_NUM_SLOTS; k++) begin
        if (idx == RPAB_IDX_ALIAS5 + 8'(k)) begin
          alias_d[k] = wb_dat_i[7:0];
        end
      end
      if (idx == RPAB_IDX_PORT_CFG) begin
        // Only the writable fields are taken
        drop_d = wb_dat_i[RPAB_CFG_DROP_BIT];
        mode_d = wb_dat_i[1:0];
      end
      if (idx == RPAB_IDX_BC_SRC) begin
        bc_d = wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < RPAB_NUM_SLOTS; k++) begin
        alias_q[k] <= RPAB_ALIAS_RST;
      end
      drop_q <= RPAB_CFG_DROP_RST;
      mode_q <= RPAB_CFG_MODE_RST;
      bc_q <= RPAB_BC_RST;
    end else begin
      alias_q <= alias_d;
      drop_q <= drop_d;
      mode_q <= mode_d;
      bc_q <= bc_d;
    end
  end

  assign input_format_select_o = mode_q;
  assign raw_mode_o = (mode_q != RPAB_MODE_RESERVED);

  // ***************************************************************
  // Alias decoder
  // ***************************************************************
  logic [6:0] tid [RPAB_NUM_SLOTS];
  logic hit_d, hit_q;
  logic [6:0] raddr_d, raddr_q;
  logic aack_d, aack_q;
  logic mw_d, mw_q;

  assign tid[0] = target_id_slot5_i;
  assign tid[1] = target_id_slot6_i;
  assign tid[2] = target_id_slot7_i;

  always_comb begin
    hit_d = 1'b0;
    slot_d = slot_q;
    raddr_d = raddr_q;
    aack_d = aack_q;
    mw_d = mw_q;
    if (txn_valid_i) begin
      // Walk downward so the lowest matching slot wins
      for (int k = RPAB_NUM_SLOTS - 1; k >= 0; k--) begin
        if (alias_q[k][7:RPAB_ALIAS_LSB] != 7'h00 &&
            alias_q[k][7:RPAB_ALIAS_LSB] == txn_addr_i) begin
          hit_d = 1'b1;
          slot_d = RPAB_FIRST_SLOT + 3'(k);
          raddr_d = tid[k];
          aack_d = alias_q[k][RPAB_AUTO_ACK_BIT];
          mw_d = txn_write_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_q <= 1'b0;
      slot_q <= 3'h0;
      raddr_q <= 7'h00;
      aack_q <= 1'b0;
      mw_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
      slot_q <= slot_d;
      raddr_q <= raddr_d;
      aack_q <= aack_d;
      mw_q <= mw_d;
    end
  end

  assign match_o = hit_q;
  assign match_slot_o = slot_q;
  assign remote_addr_o = raddr_q;
  assign match_write_o = mw_q;
  assign auto_ack_o = aack_q;
  // Auto-ack ignores lock and the remote answer
  assign i2c_ack_o = hit_q & ((mw_q & aack_q) | (fwd_lock_i & remote_ack_i));

  // ***************************************************************
  // First-line setup check
  // ***************************************************************
  logic [7:0] cnt_d, cnt_q;
  logic short_first;
  logic drop_now;
  logic fval_d, fval_q;
  logic lval_d, lval_q;
  logic tr_d, tr_q;

  always_comb begin
    short_first = line_valid_i & ((st_q == FL_IDLE & frame_valid_i) |
                                  (st_q == FL_WAIT & cnt_q < SETUP_CNT));
    drop_now = drop_q & raw_mode_o & line_valid_i & (short_first | st_q == FL_DROP);
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      FL_IDLE: begin
        cnt_d = 8'h01;
        if (frame_valid_i) begin
          st_d = line_valid_i ? (drop_now ? FL_DROP : FL_RUN) : FL_WAIT;
        end
      end
      FL_WAIT: begin
        if (!frame_valid_i) begin
          st_d = FL_IDLE;
        end else if (line_valid_i) begin
          st_d = drop_now ? FL_DROP : FL_RUN;
        end else if (cnt_q != 8'hff) begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      FL_DROP: begin
        if (!frame_valid_i) begin
          st_d = FL_IDLE;
        end else if (!line_valid_i) begin
          st_d = FL_RUN;
        end
      end
      FL_RUN: begin
        if (!frame_valid_i) begin
          st_d = FL_IDLE;
        end
      end
      default: st_d = FL_IDLE;
    endcase
    fval_d = frame_valid_i;
    lval_d = line_valid_i & ~drop_now;
    tr_d = short_first & raw_mode_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= FL_IDLE;
      cnt_q <= 8'h00;
      fval_q <= 1'b0;
      lval_q <= 1'b0;
      tr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      fval_q <= fval_d;
      lval_q <= lval_d;
      tr_q <= tr_d;
    end
  end

  assign frame_valid_o = fval_q;
  assign line_valid_o = lval_q;
  assign trunc_line_o = tr_q;

  // ***************************************************************
  // Back-channel sources
  // ***************************************************************
  rpab_bc_mux u_bc0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(bc_q[RPAB_BC_SEL1_LSB-1:0]),
    .pin_i(gpio_s2_q),
    .trigger_i(camera_trigger_signal_i),
    .bit_o(backchannel_bit0_o)
  );

  rpab_bc_mux u_bc1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(bc_q[7:RPAB_BC_SEL1_LSB]),
    .pin_i(gpio_s2_q),
    .trigger_i(camera_trigger_signal_i),
    .bit_o(backchannel_bit1_o)
  );

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ALIAS_HIT: assert property (txn_valid_i && alias_q[0][7:1] != 7'h00 &&
    alias_q[0][7:1] == txn_addr_i |=> match_o && match_slot_o == 3'h5 &&
    remote_addr_o == $past(target_id_slot5_i))
    else $error("slot 5 alias not remapped");
  AST_ALIAS_OFF: assert property (txn_valid_i && alias_q[0][7:1] == 7'h00 &&
    alias_q[1][7:1] == 7'h00 && alias_q[2][7:1] == 7'h00 |=> !match_o)
    else $error("match with all aliases zero");
  AST_AUTO_ACK: assert property (match_o && match_write_o && auto_ack_o |-> i2c_ack_o)
    else $error("auto-ack write not acknowledged");
  AST_NO_AUTO: assert property (match_o && !auto_ack_o && !remote_ack_i |-> !i2c_ack_o)
    else $error("ack without auto-ack or remote ack");
  AST_DROP: assert property (drop_now |=> !line_valid_o && frame_valid_o)
    else $error("truncated line forwarded");
  AST_SETUP_OK: assert property (st_q == FL_WAIT && cnt_q >= SETUP_CNT &&
    line_valid_i |=> line_valid_o && !trunc_line_o)
    else $error("line dropped although setup met");
  AST_FORWARD: assert property (line_valid_i && !drop_q |=> line_valid_o)
    else $error("line lost with discard off");
  AST_MODE_WR: assert property (wr_en && idx == RPAB_IDX_PORT_CFG |=>
    input_format_select_o == $past(wb_dat_i[1:0]))
    else $error("input format not written");
  AST_BC_WR: assert property (wr_en && idx == RPAB_IDX_BC_SRC |=>
    bc_q[7:4] == $past(wb_dat_i[7:4]) && bc_q[3:0] == $past(wb_dat_i[3:0]))
    else $error("back-channel source not written");
  AST_BC_RST: assert property ($past(rst_i) |-> bc_q == RPAB_BC_RST)
    else $error("back-channel source reset wrong");
  AST_RSVD: assert property (wb_ack_o && !wb_we_i && $past(idx) == RPAB_IDX_PORT_CFG |->
    wb_dat_o[7:4] == 4'h0 && wb_dat_o[2] == RSVD_BIT2)
    else $error("reserved config bits changed");

  COV_HIT: cover property (match_o && i2c_ack_o);
  COV_DROP: cover property (drop_now ##1 !line_valid_i);
  COV_FSYNC: cover property (bc_q[3:0] == RPAB_BC_FSYNC && camera_trigger_signal_i);

endmodule
`default_nettype wire

// [verif/rpab_remote_model.sv]
// Far-side serializer model with its attached targets
`timescale 1ns/1ns
`default_nettype none
module rpab_remote_model #(
  parameter logic [6:0] PRESENT_ADDR = 7'h50
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic lock_en_i,
  input wire logic [6:0] remote_addr_i,
  output logic fwd_lock_o,
  output logic remote_ack_o
);
  logic lock_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_en_i;
    end
  end
  // Only a locked link with a fitted target answers
  assign fwd_lock_o = lock_q;
  assign remote_ack_o = lock_q & (remote_addr_i == PRESENT_ADDR);
endmodule
`default_nettype wire

// [verif/test_rx_port_alias_backchannel_cfg.sv]
// Self-checking bench for the alias, input format and back-channel bank
`timescale 1ns/1ns
`default_nettype none
module test_rx_port_alias_backchannel_cfg;
  import rpab_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tv = 1'b0, tw = 1'b0;
  logic lock_en = 1'b0, fval = 1'b0, lval = 1'b0, trig = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [6:0] tgt5 = 7'h50, tgt6 = 7'h51, tgt7 = 7'h52;
  logic [9:0] adr = 10'h000;
  logic [7:0] wdat = 8'h00, pins = 8'h00;
  logic [6:0] ta = 7'h00;
  logic [31:0] rdat;
  logic ack, fwd_lock, rack, match, mw, aack, i2c_ack, fval_out, lval_out;
  logic trunc, raw, bc0, bc1;
  logic [2:0] mslot;
  logic [6:0] raddr;
  logic [1:0] fmt;
  logic [3:0] c;
  logic e;
  int num_errors = 0, checked = 0, cycles = 0;

  rpab_cfg #(.SETUP_CYC(2), .RSVD_BIT2(1'b0)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i({24'h000000, wdat}), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .txn_valid_i(tv), .txn_addr_i(ta), .txn_write_i(tw),
    .target_id_slot5_i(tgt5), .target_id_slot6_i(tgt6), .target_id_slot7_i(tgt7),
    .fwd_lock_i(fwd_lock), .remote_ack_i(rack), .match_o(match), .match_slot_o(mslot),
    .remote_addr_o(raddr), .match_write_o(mw), .auto_ack_o(aack), .i2c_ack_o(i2c_ack),
    .frame_valid_i(fval), .line_valid_i(lval),
    .frame_valid_o(fval_out), .line_valid_o(lval_out),
    .trunc_line_o(trunc), .input_format_select_o(fmt), .raw_mode_o(raw),
    .gpio_pin_i(pins), .camera_trigger_signal_i(trig),
    .backchannel_bit0_o(bc0), .backchannel_bit1_o(bc1));

  rpab_remote_model #(.PRESENT_ADDR(7'h50)) remote (
    .clk_i(clk_i), .rst_i(rst_i), .lock_en_i(lock_en), .remote_addr_i(raddr),
    .fwd_lock_o(fwd_lock), .remote_ack_o(rack));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] x, input string m);
    logic [7:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk(r, x, m);
  endtask

  task automatic txn(input logic [6:0] a, input logic w, input logic em,
                     input logic [2:0] es, input logic [6:0] ea, input logic eack);
    tv <= 1'b1;
    ta <= a;
    tw <= w;
    @(posedge clk_i);
    tv <= 1'b0;
    @(negedge clk_i);
    if (em) begin
      chk({mw, i2c_ack, match, mslot, raddr}, {w, eack, 1'b1, es, ea}, "decode");
    end else begin
      chk(match, 1'b0, "no decode");
    end
    @(posedge clk_i);
  endtask

  // Frame with one line of eight cycles after the given setup
  task automatic line(input int setup, input logic elv, input logic etr);
    int cnt;
    int fc;
    logic tr;
    cnt = 0;
    fc = 0;
    tr = 1'b0;
    fval <= 1'b1;
    repeat (setup) @(posedge clk_i);
    lval <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      if (i == 8) begin
        lval <= 1'b0;
      end
      @(posedge clk_i);
      cnt += lval_out;
      fc += fval_out;
      tr |= trunc;
    end
    fval <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(cnt, elv ? 16'h0008 : 16'h0000, "line cycles");
    chk(fc, 16'h000b, "frame cycles");
    chk(tr, etr, "truncated flag");
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test;
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(RPAB_IDX_ALIAS5, 8'h00, "alias5 reset");
    rd(RPAB_IDX_ALIAS6, 8'h00, "alias6 reset");
    rd(RPAB_IDX_ALIAS7, 8'h00, "alias7 reset");
    rd(RPAB_IDX_PORT_CFG, 8'h08, "cfg reset");
    rd(RPAB_IDX_BC_SRC, 8'h88, "bc reset");
    chk({bc1, bc0}, 2'h0, "bc after reset");
    $display("test reset done");
    wr(RPAB_IDX_PORT_CFG, 8'hff);
    rd(RPAB_IDX_PORT_CFG, 8'h0b, "cfg read-only bits");
    sel <= 4'he;
    wr(RPAB_IDX_PORT_CFG, 8'h00);
    sel <= 4'hf;
    rd(RPAB_IDX_PORT_CFG, 8'h0b, "write without byte select");
    wr(8'h40, 8'h55);
    rd(8'h40, 8'h00, "unmapped");
    for (int m = 0; m < 4; m++) begin
      wr(RPAB_IDX_PORT_CFG, {6'h02, m[1:0]});
      chk({raw, fmt}, {m != 0, m[1:0]}, "input format");
    end
    $display("test config done");
    txn(7'h21, 1'b1, 1'b0, 3'h0, 7'h00, 1'b0);
    wr(RPAB_IDX_ALIAS5, 8'h43);
    wr(RPAB_IDX_ALIAS6, 8'h42);
    wr(RPAB_IDX_ALIAS7, 8'h66);
    rd(RPAB_IDX_ALIAS5, 8'h43, "alias5 back");
    txn(7'h21, 1'b1, 1'b1, 3'h5, 7'h50, 1'b1);
    chk(aack, 1'b1, "auto-ack flag");
    txn(7'h21, 1'b0, 1'b1, 3'h5, 7'h50, 1'b0);
    txn(7'h33, 1'b1, 1'b1, 3'h7, 7'h52, 1'b0);
    chk(aack, 1'b0, "no auto-ack flag");
    lock_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    txn(7'h21, 1'b0, 1'b1, 3'h5, 7'h50, 1'b1);
    txn(7'h33, 1'b1, 1'b1, 3'h7, 7'h52, 1'b0);
    tgt5 <= 7'h2a;
    txn(7'h21, 1'b0, 1'b1, 3'h5, 7'h2a, 1'b0);
    wr(RPAB_IDX_ALIAS5, 8'h01);
    wr(RPAB_IDX_ALIAS7, 8'h00);
    txn(7'h00, 1'b1, 1'b0, 3'h0, 7'h00, 1'b0);
    txn(7'h21, 1'b1, 1'b1, 3'h6, 7'h51, 1'b0);
    rd(RPAB_IDX_STATUS, 8'h60, "status slot");
    $display("test decode done");
    line(1, 1'b0, 1'b1);
    line(3, 1'b1, 1'b0);
    wr(RPAB_IDX_PORT_CFG, 8'h03);
    line(1, 1'b1, 1'b1);
    wr(RPAB_IDX_PORT_CFG, 8'h08);
    line(1, 1'b1, 1'b0);
    $display("test video done");
    pins <= 8'h5a;
    trig <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      wr(RPAB_IDX_BC_SRC, {c, c});
      repeat (3) @(posedge clk_i);
      e = c[3] ? (c == 4'h9 || (c == 4'ha && trig)) : pins[c[2:0]];
      chk({bc1, bc0}, {e, e}, "bc source");
    end
    wr(RPAB_IDX_BC_SRC, 8'h98);
    repeat (3) @(posedge clk_i);
    chk({bc1, bc0}, 2'h2, "bc fields");
    wr(RPAB_IDX_BC_SRC, 8'haa);
    trig <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({bc1, bc0}, 2'h0, "frame sync low");
    trig <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({bc1, bc0}, 2'h3, "frame sync high");
    $display("test backchannel done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(RPAB_IDX_BC_SRC, 8'h88, "bc second reset");
    chk({bc1, bc0}, 2'h0, "bc bits second reset");
    rd(RPAB_IDX_ALIAS6, 8'h00, "alias6 second reset");
    rd(RPAB_IDX_PORT_CFG, 8'h08, "cfg second reset");
    $display("test second reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
